//--- logic/txsa_pkg.sv
// Purpose: Constants, register map and types of the transmit audio and sub-audio processor
// Assumes: 200 MHz mclk, 8 kHz audio sample rate
// Notes: Register offsets are the byte addresses sent in the serial address byte
package txsa_pkg;
  // ********************************
  // Timing
  // ********************************
  localparam int MCLK_HZ = 200_000_000;
  localparam int SAMPLE_HZ = 8000;
  localparam int SAMPLE_DIV = MCLK_HZ / SAMPLE_HZ;
  localparam int SAMPLE_DHZ = SAMPLE_HZ * 10;
  localparam int INC_MUL = (65536 * 1024) / SAMPLE_DHZ;
  localparam logic [11:0] INV_DEF_DHZ = 12'hCE4;
  localparam logic [11:0] DCS_RATE_DHZ = 12'h540;
  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] ADDR_TX_OUT_MODE = 8'hA7;
  localparam logic [7:0] ADDR_OUT_GAIN = 8'hB0;
  localparam logic [7:0] ADDR_IN_GAIN = 8'hB1;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'hC1;
  localparam logic [7:0] ADDR_AUDIO_CTRL = 8'hC2;
  localparam logic [7:0] ADDR_STATUS = 8'hC6;
  localparam logic [7:0] ADDR_PARAM = 8'hC8;
  localparam logic [7:0] ADDR_TONE_STATUS = 8'hCC;
  // ********************************
  // Fields
  // ********************************
  localparam logic [1:0] ROUTE_COMPOSITE = 2'h0;
  localparam logic [1:0] ROUTE_SPLIT = 2'h1;
  localparam logic [1:0] ROUTE_IQ = 2'h2;
  localparam int OG_INV1 = 0;
  localparam int OG_INV2 = 1;
  localparam int IG_MIC_SEL = 3;
  localparam logic [1:0] MODE_CODE_RX = 2'h1;
  localparam logic [1:0] MODE_CODE_TX = 2'h2;
  localparam int MC_CTCSS_EN = 2;
  localparam int MC_DCS_EN = 3;
  localparam int AC_HPF = 8;
  localparam int AC_PREEMPH = 9;
  localparam int AC_WIDE = 10;
  localparam int AC_COMPAND = 11;
  localparam int AC_SCRAMBLE = 12;
  localparam int AC_PHASE_REV = 13;
  localparam int AC_DCS24 = 14;
  localparam int ST_TONE = 11;
  localparam int TS_PHASE = 9;
  localparam logic [3:0] PID_AGC = 4'h1;
  localparam logic [3:0] PID_INV = 4'h2;
  localparam logic [3:0] PID_DECODER = 4'h3;
  localparam logic [3:0] PID_DCS_LO = 4'h4;
  localparam logic [3:0] PID_DCS_HI = 4'h5;
  localparam logic [3:0] PID_USER_TONE = 4'h6;
  // ********************************
  // Sub-audio codes
  // ********************************
  localparam logic [7:0] CODE_DCS_LAST = 8'h54;
  localparam logic [7:0] CODE_IDCS_FIRST = 8'h65;
  localparam logic [7:0] CODE_IDCS_LAST = 8'hB8;
  localparam logic [7:0] CODE_TONE_FIRST = 8'hC9;
  localparam logic [7:0] CODE_TONE_LAST = 8'hFE;
  localparam logic [7:0] CODE_USER_TONE = 8'hFC;
  localparam logic [7:0] CODE_UNRECOG = 8'hFF;
  localparam logic [11:0] TONE_DHZ [0:53] = '{
    12'd670, 12'd719, 12'd744, 12'd770, 12'd797, 12'd825, 12'd854, 12'd885, 12'd915, 12'd948,
    12'd974, 12'd1000, 12'd1035, 12'd1072, 12'd1109, 12'd1148, 12'd1188, 12'd1230, 12'd1273,
    12'd1318, 12'd1365, 12'd1413, 12'd1462, 12'd1514, 12'd1567, 12'd1622, 12'd1679, 12'd1738,
    12'd1799, 12'd1862, 12'd1928, 12'd2035, 12'd2107, 12'd2181, 12'd2257, 12'd2336, 12'd2418,
    12'd2503, 12'd693, 12'd625, 12'd1598, 12'd1655, 12'd1713, 12'd1773, 12'd1835, 12'd1899,
    12'd1966, 12'd1995, 12'd2065, 12'd2291, 12'd2541, 12'd0, 12'd647, 12'd1344};
  // ********************************
  // Signal processing constants
  // ********************************
  localparam logic [11:0] GAIN_Q8 [0:7] = '{12'h100, 12'h172, 12'h217, 12'h305,
    12'h45D, 12'h64F, 12'h91F, 12'hD2E};
  localparam int HPF_SH = 3;
  localparam int ENV_SH = 5;
  localparam logic [3:0] ENV_REF = 4'hC;
  localparam logic signed [15:0] LIMIT = 16'sh6000;
  localparam int SUB_SH = 3;
  localparam int IQ_SH = 4;
  localparam logic [15:0] QUARTER = 16'h4000;
  localparam logic [15:0] HALF = 16'h8000;
  localparam logic signed [15:0] DCS_AMP = 16'sh0800;
  localparam logic [7:0] PER_MAX = 8'hFF;
  localparam logic [7:0] PER_SUBAUDIO = 8'h1F;
  localparam int BW_SCALE = 64;
  localparam int PHASE_ERR = SAMPLE_DHZ / 4;
  typedef enum logic [1:0] {TXSA_IDLE, TXSA_RX, TXSA_TX} txsa_mode_t;
  typedef struct packed {
    logic [15:0] modulator_output_one;
    logic [15:0] modulator_output_two;
  } txsa_mod_t;
endpackage

//--- logic/txsa_core.sv
// Purpose: Transmit audio chain, sub-audio coding and tone detection with serial register port
// Assumes: Serial pins and samples are synchronous to mclk; ctl_sclk well below mclk/4
// Notes: Frame is 8 address bits then 16 data bits, MSB first, mosi sampled on sclk rise
// Function
// [R01] Mic via gain stage selectable as source
// [R02] 300Hz high-pass removes sub-audio band
// [R03] Optional +6dB/octave pre-emphasis
// [R04] Pre-emphasis with either channel filter, limited
// [R05] Composite on both outputs or split
// [R06] Alternative I/Q output of composite
// [R07] AGC captures gain, steps down on overload
// [R08] AGC recovers stepwise to captured gain
// [R09] AGC detector source selectable
// [R10] Host rewrites gain before each transmit
// [R11] Scrambler inversion 3300Hz default, overridable
// [R12] Syllabic compressor, half level change
// [R13] 60dB maps to 30dB, expandor inverse
// [R14] Compress in transmit, expand in receive
// [R15] Sub-audio below 260Hz, host enables HPF
// [R16] Audio control low byte selects code
// [R17] Separate enables keep selected code
// [R18] DCS 23/24 bit, true/inverted, 134Hz burst
// [R19] Valid CTCSS sets status bit 11
// [R20] Decoder bandwidth and threshold programmable
// [R21] Phase shift sets tone bit 9, status 11
// [R22] Reverse burst by output invert or phase
// [R23] Idle, receive, transmit; idle after reset
`timescale 1ns/1ps
`default_nettype none
module txsa_core
  import txsa_pkg::*;
#(
  parameter int SAMPLE_DIV_P = txsa_pkg::SAMPLE_DIV
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial control port
  input wire logic ctl_cs_n,
  input wire logic ctl_sclk,
  input wire logic ctl_mosi,
  output logic ctl_miso,
  // Audio samples
  input wire logic [15:0] mic_sample,
  input wire logic [15:0] line_sample,
  input wire logic [15:0] rx_sample,
  // Outputs
  output txsa_pkg::txsa_mod_t mod_out,
  output logic [15:0] rx_audio
);
  typedef struct packed {
    txsa_mode_t mode;
    logic prev_sclk;
    logic [4:0] bitcnt;
    logic [23:0] sh;
    logic [15:0] rd_sh;
    logic miso;
    logic [15:0] r_a7, r_b0, r_b1, r_c1, r_c2;
    logic [11:0] p_agc, p_inv, p_dec, p_dcs_lo, p_dcs_hi, p_user;
    logic [15:0] div_cnt;
    logic [15:0] hp1, hp2, pre_x1, chan_lp, env, rx_env;
    logic [15:0] scr_ph, tone_ph, dcs_ph, iq_ph;
    logic [23:0] dcs_sh;
    logic [2:0] agc_gain, agc_cap;
    logic [9:0] agc_hold;
    logic prev_sign;
    logic [7:0] per_cnt;
    logic [5:0] match_cnt;
    logic [7:0] tone_no;
    logic tone_flag, phase_flag;
    txsa_mod_t mod;
    logic [15:0] rx_out;
  } txsa_state_t;

  txsa_state_t st_r, st_nxt;

  // ********************************
  // Helpers
  // ********************************
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) return 16'sh7FFF;
    if (v < -32'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic signed [15:0] sine(input logic [15:0] ph);
    logic [14:0] x;
    logic [29:0] p;
    x = ph[14:0];
    p = x * (15'h7FFF - x);
    return ph[15] ? -$signed({1'b0, p[28:14]}) : $signed({1'b0, p[28:14]});
  endfunction

  function automatic logic [15:0] inc_of(input logic [11:0] dhz);
    logic [31:0] m;
    m = dhz * 32'(INC_MUL);
    return m[25:10];
  endfunction

  function automatic logic [3:0] msb16(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) r = 4'(i);
    end
    return r;
  endfunction

  function automatic logic signed [15:0] shl(input logic signed [15:0] x, input logic signed [5:0] s);
    logic signed [31:0] w;
    w = 32'(x);
    if (s >= 0) return sat16(w <<< s);
    return sat16(w >>> (-s));
  endfunction

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    logic tick, rise, fall, ctcss_on, dcs_on, dcs_inv, agc_on, clr_rd;
    logic [7:0] addr, code;
    logic [15:0] data;
    logic [2:0] g;
    logic signed [15:0] src, x0, a, x1, x2, x3, x4, x5, sub, comp, lvl;
    logic signed [31:0] prod;
    logic [31:0] err;
    logic [16:0] dacc;
    logic [11:0] fdhz;
    logic [4:0] dlen;
    logic signed [5:0] csh;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    clr_rd = 1'b0;
    addr = 8'h0;
    data = 16'h0;
    st_nxt = st_r;
    // Sample rate enable
    tick = (st_r.div_cnt == 16'(SAMPLE_DIV_P - 1));
    st_nxt.div_cnt = tick ? 16'h0 : st_r.div_cnt + 16'h1;
    // Serial register port
    rise = ctl_sclk & ~st_r.prev_sclk;
    fall = ~ctl_sclk & st_r.prev_sclk;
    st_nxt.prev_sclk = ctl_sclk;
    if (ctl_cs_n) begin
      st_nxt.bitcnt = 5'h0;
    end else if (rise) begin
      st_nxt.sh = {st_r.sh[22:0], ctl_mosi};
      st_nxt.bitcnt = st_r.bitcnt + 5'h1;
      if (st_r.bitcnt == 5'h7) begin
        addr = {st_r.sh[6:0], ctl_mosi};
        clr_rd = 1'b1;
        if (addr == ADDR_STATUS) begin
          st_nxt.rd_sh = {4'h0, st_r.tone_flag | st_r.phase_flag, 9'h0, 2'(st_r.mode)}; // R19 R21
        end else if (addr == ADDR_TONE_STATUS) begin
          st_nxt.rd_sh = {6'h0, st_r.phase_flag, 1'b0, st_r.tone_no}; // R21
        end else begin
          st_nxt.rd_sh = 16'h0;
          clr_rd = 1'b0;
        end
      end
      if (st_r.bitcnt == 5'h17) begin
        addr = st_r.sh[22:15];
        data = {st_r.sh[14:0], ctl_mosi};
        unique case (addr)
          ADDR_TX_OUT_MODE: st_nxt.r_a7 = data;
          ADDR_OUT_GAIN: st_nxt.r_b0 = data;
          ADDR_IN_GAIN: st_nxt.r_b1 = data;
          ADDR_AUDIO_CTRL: st_nxt.r_c2 = data; // R16
          ADDR_MODE_CTRL: begin
            st_nxt.r_c1 = data; // R17
            if (data[1:0] == MODE_CODE_TX) begin
              st_nxt.mode = TXSA_TX; // R23
              if (st_r.mode != TXSA_TX) begin
                st_nxt.agc_cap = st_r.r_b1[2:0]; // R07
                st_nxt.agc_gain = st_r.r_b1[2:0];
                st_nxt.agc_hold = 10'h0;
              end
            end else if (data[1:0] == MODE_CODE_RX) begin
              st_nxt.mode = TXSA_RX;
            end else begin
              st_nxt.mode = TXSA_IDLE;
            end
          end
          ADDR_PARAM: begin
            if (st_r.mode == TXSA_IDLE) begin
              unique case (data[15:12])
                PID_AGC: st_nxt.p_agc = data[11:0];
                PID_INV: st_nxt.p_inv = data[11:0]; // R11
                PID_DECODER: st_nxt.p_dec = data[11:0]; // R20
                PID_DCS_LO: st_nxt.p_dcs_lo = data[11:0];
                PID_DCS_HI: st_nxt.p_dcs_hi = data[11:0];
                PID_USER_TONE: st_nxt.p_user = data[11:0];
                default: st_nxt.p_agc = st_r.p_agc;
              endcase
            end
          end
          default: st_nxt.r_a7 = st_r.r_a7;
        endcase
      end
    end else if (fall && st_r.bitcnt >= 5'h8) begin
      st_nxt.miso = st_r.rd_sh[15];
      st_nxt.rd_sh = {st_r.rd_sh[14:0], 1'b0};
    end
    if (clr_rd) begin
      st_nxt.phase_flag = 1'b0;
    end
    // Sub-audio code decode
    code = st_r.r_c2[7:0];
    ctcss_on = st_r.r_c1[MC_CTCSS_EN] && code >= CODE_TONE_FIRST && code <= CODE_TONE_LAST; // R16 R17
    dcs_on = st_r.r_c1[MC_DCS_EN] && ((code != 8'h0 && code <= CODE_DCS_LAST) ||
      (code >= CODE_IDCS_FIRST && code <= CODE_IDCS_LAST)); // R16 R17
    dcs_inv = code >= CODE_IDCS_FIRST; // R18
    fdhz = (code == CODE_USER_TONE) ? st_r.p_user : TONE_DHZ[6'(code - CODE_TONE_FIRST)];
    agc_on = st_r.p_agc[0];
    g = agc_on ? st_r.agc_gain : st_r.r_b1[2:0];
    src = st_r.r_b1[IG_MIC_SEL] ? mic_sample : line_sample; // R01
    x0 = sat16((32'(src) * $signed({20'h0, GAIN_Q8[g]})) >>> 8); // R01
    x1 = x0;
    x2 = x0;
    x3 = x0;
    x4 = x0;
    x5 = x0;
    a = x0;
    sub = 16'sh0;
    comp = 16'sh0;
    lvl = x0;
    prod = 32'sh0;
    err = 32'h0;
    dacc = 17'h0;
    dlen = 5'h0;
    csh = 6'sh0;
    // ********************************
    // Transmit path
    // ********************************
    if (tick && st_r.mode == TXSA_TX) begin
      if (st_r.r_c2[AC_HPF]) begin
        st_nxt.hp1 = sat16(32'($signed(st_r.hp1)) + ((32'(x0) - 32'($signed(st_r.hp1))) >>> HPF_SH)); // R02 R15
        a = sat16(32'(x0) - 32'($signed(st_r.hp1)));
        st_nxt.hp2 = sat16(32'($signed(st_r.hp2)) + ((32'(a) - 32'($signed(st_r.hp2))) >>> HPF_SH));
        x1 = sat16(32'(a) - 32'($signed(st_r.hp2))); // R02
      end
      st_nxt.pre_x1 = x1;
      x2 = st_r.r_c2[AC_PREEMPH] ? sat16(32'(x1) - ((32'($signed(st_r.pre_x1)) * 3) >>> 2)) : x1; // R03 R04
      lvl = st_r.p_agc[1] ? x2 : x0; // R09
      if (st_r.r_c2[AC_COMPAND]) begin
        st_nxt.env = 16'(st_r.env + ((32'(abs16(x2)) - 32'(st_r.env)) >>> ENV_SH)); // R12
        csh = (6'($signed({1'b0, ENV_REF})) - 6'($signed({1'b0, msb16(st_r.env)}))) >>> 1; // R12 R13
        x3 = shl(x2, csh); // R14
      end else begin
        x3 = x2;
      end
      if (st_r.r_c2[AC_SCRAMBLE]) begin
        // Inversion frequency is held in Hz, the tone table in tenths of Hz
        st_nxt.scr_ph = st_r.scr_ph + 16'(32'(inc_of(st_r.p_inv)) * (SAMPLE_DHZ / SAMPLE_HZ)); // R11
        x4 = sat16((32'(x3) * 32'(sine(st_r.scr_ph))) >>> 14);
      end else begin
        x4 = x3;
      end
      st_nxt.chan_lp = sat16(32'($signed(st_r.chan_lp)) +
        ((32'(x4) - 32'($signed(st_r.chan_lp))) >>> (st_r.r_c2[AC_WIDE] ? 1 : 2))); // R04
      x5 = $signed(st_r.chan_lp) > LIMIT ? LIMIT : ($signed(st_r.chan_lp) < -LIMIT ? -LIMIT : st_r.chan_lp);
      if (ctcss_on) begin
        st_nxt.tone_ph = st_r.tone_ph + inc_of(fdhz);
        sub = sine(st_r.tone_ph + (st_r.r_c2[AC_PHASE_REV] ? HALF : 16'h0)) >>> SUB_SH; // R22
      end else if (dcs_on) begin
        dacc = {1'b0, st_r.dcs_ph} + {1'b0, inc_of(DCS_RATE_DHZ)}; // R18
        st_nxt.dcs_ph = dacc[15:0];
        dlen = st_r.r_c2[AC_DCS24] ? 5'h17 : 5'h16;
        if (dacc[16]) begin
          st_nxt.dcs_sh = {1'b0, st_r.dcs_sh[23:1]};
          st_nxt.dcs_sh[dlen] = st_r.dcs_sh[0]; // R18
          // An empty word is loaded from the programmed code, trimmed to its length
          if (st_r.dcs_sh == 24'h0) begin
            st_nxt.dcs_sh = {st_r.p_dcs_hi, st_r.p_dcs_lo} & (24'hFFFFFF >> (5'h17 - dlen)); // R18
          end
        end
        sub = (st_r.dcs_sh[0] ^ dcs_inv) ? DCS_AMP : -DCS_AMP; // R18
      end
      comp = sat16(32'(x5) + 32'(sub));
      if (agc_on) begin
        if (abs16(lvl) > {1'b0, st_r.p_agc[11:6], 9'h0}) begin
          st_nxt.agc_hold = 10'h0;
          if (st_r.agc_gain != 3'h0) begin
            st_nxt.agc_gain = st_r.agc_gain - 3'h1; // R07
          end
        end else if (st_r.agc_gain < st_r.agc_cap) begin
          st_nxt.agc_hold = st_r.agc_hold + 10'h1;
          if (st_r.agc_hold == {st_r.p_agc[5:2], 6'h3F}) begin
            st_nxt.agc_hold = 10'h0;
            st_nxt.agc_gain = st_r.agc_gain + 3'h1; // R08
          end
        end
      end
      unique case (st_r.r_a7[1:0])
        ROUTE_SPLIT: begin
          st_nxt.mod.modulator_output_one = x5; // R05
          st_nxt.mod.modulator_output_two = sub;
        end
        ROUTE_IQ: begin
          st_nxt.iq_ph = st_r.iq_ph + 16'(comp >>> IQ_SH); // R06
          st_nxt.mod.modulator_output_one = sine(st_r.iq_ph + QUARTER);
          st_nxt.mod.modulator_output_two = sine(st_r.iq_ph);
        end
        default: begin
          st_nxt.mod.modulator_output_one = comp; // R05
          st_nxt.mod.modulator_output_two = comp;
        end
      endcase
      if (st_r.r_b0[OG_INV1]) begin
        st_nxt.mod.modulator_output_one = sat16(-32'($signed(st_nxt.mod.modulator_output_one))); // R22
      end
      if (st_r.r_b0[OG_INV2]) begin
        st_nxt.mod.modulator_output_two = sat16(-32'($signed(st_nxt.mod.modulator_output_two))); // R22
      end
    end else if (st_r.mode != TXSA_TX) begin
      st_nxt.mod = '0;
    end
    // ********************************
    // Receive path
    // ********************************
    if (tick && st_r.mode == TXSA_RX) begin
      if (st_r.r_c2[AC_COMPAND]) begin
        st_nxt.rx_env = 16'(st_r.rx_env + ((32'(abs16(rx_sample)) - 32'(st_r.rx_env)) >>> ENV_SH));
        csh = 6'($signed({1'b0, msb16(st_r.rx_env)})) - 6'($signed({1'b0, ENV_REF}));
        st_nxt.rx_out = shl(rx_sample, csh); // R13 R14
      end else begin
        st_nxt.rx_out = rx_sample;
      end
      st_nxt.prev_sign = rx_sample[15];
      if (st_r.per_cnt != PER_MAX) begin
        st_nxt.per_cnt = st_r.per_cnt + 8'h1;
      end else begin
        st_nxt.tone_flag = 1'b0;
        st_nxt.tone_no = 8'h0;
        st_nxt.match_cnt = 6'h0;
      end
      if (st_r.prev_sign && !rx_sample[15]) begin
        // The crossing sample is the first of the new period
        st_nxt.per_cnt = 8'h1;
        prod = $signed({24'h0, st_r.per_cnt}) * $signed({20'h0, fdhz});
        err = 32'(abs16(16'(prod - 32'(SAMPLE_DHZ))));
        if (prod - 32'(SAMPLE_DHZ) > 32'sd32767 || prod - 32'(SAMPLE_DHZ) < -32'sd32767) begin
          err = 32'h7FFF;
        end
        if (!ctcss_on) begin
          st_nxt.match_cnt = 6'h0;
          st_nxt.tone_flag = 1'b0;
          st_nxt.tone_no = 8'h0;
        end else if (err <= 32'(st_r.p_dec[5:0]) * BW_SCALE) begin
          if (st_r.match_cnt != 6'h3F) begin
            st_nxt.match_cnt = st_r.match_cnt + 6'h1; // R20
          end
          if (st_r.match_cnt >= st_r.p_dec[11:6]) begin
            st_nxt.tone_flag = 1'b1; // R19
            st_nxt.tone_no = code;
          end
        end else if (st_r.tone_flag && err >= 32'(PHASE_ERR)) begin
          st_nxt.phase_flag = 1'b1; // R21
        end else begin
          st_nxt.match_cnt = 6'h0;
          st_nxt.tone_flag = 1'b0;
          st_nxt.tone_no = (st_r.per_cnt > PER_SUBAUDIO) ? CODE_UNRECOG : 8'h0; // R15
        end
      end
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.mode <= TXSA_IDLE; // R23
      st_r.p_inv <= INV_DEF_DHZ; // R11
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctl_miso = st_r.miso;
  assign mod_out = st_r.mod;
  assign rx_audio = st_r.rx_out;
endmodule
`default_nettype wire

//--- test/txsa_core_props.sv
// Purpose: Port-level assertions for txsa_core
// Assumes: One mclk domain; frames follow the serial contract
// Notes: Mode, route and invert writes are mirrored from the frames
`timescale 1ns/1ps
`default_nettype none
module txsa_core_props
  import txsa_pkg::*;
#(
  parameter int SAMPLE_DIV_P = txsa_pkg::SAMPLE_DIV
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial port
  input wire logic ctl_cs_n,
  input wire logic ctl_sclk,
  input wire logic ctl_mosi,
  input wire logic ctl_miso,
  // Outputs
  input wire txsa_pkg::txsa_mod_t mod_out,
  input wire logic [15:0] rx_audio
);
  localparam int SETTLE = 3 * SAMPLE_DIV_P + 8;
  logic sck_d;
  logic [4:0] cnt;
  logic [22:0] sh;
  logic [3:0] mode_r;
  logic [1:0] route_r, inv_r;
  int age, since;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Age restarts on every committed write so outputs get time to follow
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {sck_d, cnt, sh, mode_r, route_r, inv_r} <= 37'h0;
      age <= 0;
      since <= 0;
    end else begin
      sck_d <= ctl_sclk;
      since <= $changed(mod_out) ? 0 : since + 1;
      age <= (age > SETTLE) ? age : age + 1;
      if (ctl_cs_n) begin
        cnt <= 5'h00;
      end else if (ctl_sclk && !sck_d) begin
        cnt <= cnt + 5'h01;
        sh <= {sh[21:0], ctl_mosi};
        if (cnt == 5'h17) begin
          age <= 0;
          if (sh[22:15] == ADDR_MODE_CTRL) mode_r <= {sh[2:0], ctl_mosi};
          if (sh[22:15] == ADDR_TX_OUT_MODE) route_r <= {sh[0], ctl_mosi};
          if (sh[22:15] == ADDR_OUT_GAIN) inv_r <= {sh[0], ctl_mosi};
        end
      end
    end
  end
  sequence tx_ok;
    age > SETTLE && mode_r[1:0] == MODE_CODE_TX;
  endsequence
  reset_out_zero_a:
    assert property ($rose(rst_n) |-> mod_out == 32'h00000000 && rx_audio == 16'h0000 && !ctl_miso)
    else $error("Outputs not clear after reset");
  idle_out_zero_a:
    assert property (age > SETTLE && mode_r[1:0] != MODE_CODE_TX |-> mod_out == 32'h00000000)
    else $error("Modulator active outside transmit");
  composite_same_a:
    assert property (tx_ok ##0 (route_r == ROUTE_COMPOSITE && inv_r[0] == inv_r[1]) |-> mod_out.modulator_output_one == mod_out.modulator_output_two)
    else $error("Composite outputs differ");
  invert_two_a:
    assert property (tx_ok ##0 (route_r == ROUTE_COMPOSITE && inv_r == 2'h2)
      |-> mod_out.modulator_output_two == 16'h0000 - mod_out.modulator_output_one || mod_out.modulator_output_two == ~mod_out.modulator_output_one)
    else $error("Second output not inverted");
  split_quiet_a:
    assert property (tx_ok ##0 (route_r == ROUTE_SPLIT && mode_r[3:2] == 2'h0) |-> mod_out.modulator_output_two == 16'h0000)
    else $error("Sub-audio output active with signalling off");
  tick_paced_a:
    assert property (tx_ok ##0 $changed(mod_out) |-> since % SAMPLE_DIV_P == SAMPLE_DIV_P - 1)
    else $error("Modulator changed off the sample tick");
  rx_hold_a:
    assert property (tx_ok |-> $stable(rx_audio))
    else $error("Receive audio moved in transmit");
  miso_on_fall_a:
    assert property ($changed(ctl_miso) |-> !ctl_sclk)
    else $error("Read data changed with serial clock high");
endmodule
bind txsa_core txsa_core_props #(.SAMPLE_DIV_P(SAMPLE_DIV_P)) txsa_core_props_inst (
  .mclk(mclk), .rst_n(rst_n), .ctl_cs_n(ctl_cs_n), .ctl_sclk(ctl_sclk), .ctl_mosi(ctl_mosi),
  .ctl_miso(ctl_miso), .mod_out(mod_out), .rx_audio(rx_audio));
`default_nettype wire

//--- test/txsa_host.sv
// Purpose: Host controller model driving serial frames
// Assumes: Called from the bench at falling mclk edges
// Notes: Four mclk per serial clock phase
`timescale 1ns/1ps
`default_nettype none
module txsa_host (
  // Clock
  input wire logic mclk,
  // Serial port
  output logic ctl_cs_n,
  output logic ctl_sclk,
  output logic ctl_mosi,
  input wire logic ctl_miso
);
  initial begin
    ctl_cs_n = 1'b1;
    ctl_sclk = 1'b0;
    ctl_mosi = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask
  task automatic xfer(input logic [7:0] a, input logic [15:0] wd, output logic [15:0] rdat);
    logic [23:0] frame;
    frame = {a, wd};
    rdat = 16'h0000;
    @(negedge mclk);
    ctl_cs_n = 1'b0;
    for (int r = 0; r < 24; r++) begin
      ctl_mosi = frame[23 - r];
      half();
      if (r >= 8) rdat[23 - r] = ctl_miso;
      ctl_sclk = 1'b1;
      half();
      ctl_sclk = 1'b0;
    end
    half();
    ctl_cs_n = 1'b1;
    // Released line must not keep showing the last bit
    ctl_mosi = ~ctl_mosi;
    half();
  endtask
endmodule
`default_nettype wire

//--- test/txsa_core_tb_top.sv
// Purpose: Self-checking bench for txsa_core over the serial port
// Assumes: Sample divider shortened to 20 mclk
// Notes: Output activity means any non-zero sample in a window
`timescale 1ns/1ps
`default_nettype none
module txsa_core_tb_top;
  import txsa_pkg::*;
  localparam int DIV = 20;
  logic mclk, rst_n, ctl_cs_n, ctl_sclk, ctl_mosi, ctl_miso, m1, m2;
  logic tone_flip = 1'b0;
  logic [15:0] mic_sample, line_sample, rx_sample, rx_audio, rd;
  txsa_mod_t mod_out;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int tick = 0;
  logic [7:0] codes [0:7] = '{8'h01, 8'h54, 8'h65, 8'hB8, 8'hC9, 8'hEE, 8'hFD, 8'hFE};
  logic [3:0] outs [0:2] = '{{ROUTE_COMPOSITE, 2'h2}, {ROUTE_COMPOSITE, 2'h3}, {ROUTE_IQ, 2'h0}};
  assign mic_sample = tick[3] ? 16'h0C00 : 16'hF400;
  assign line_sample = 16'h0000;
  // 250 Hz square at 8 kHz; flipping it reverses the tone phase
  assign rx_sample = (tick[4] ^ tone_flip) ? 16'h2000 : 16'hE000;
  txsa_core #(.SAMPLE_DIV_P(DIV)) txsa_core_inst (
    .mclk(mclk), .rst_n(rst_n), .ctl_cs_n(ctl_cs_n), .ctl_sclk(ctl_sclk), .ctl_mosi(ctl_mosi),
    .ctl_miso(ctl_miso), .mic_sample(mic_sample), .line_sample(line_sample), .rx_sample(rx_sample),
    .mod_out(mod_out), .rx_audio(rx_audio));
  txsa_host txsa_host_inst (.mclk(mclk), .ctl_cs_n(ctl_cs_n), .ctl_sclk(ctl_sclk), .ctl_mosi(ctl_mosi),
    .ctl_miso(ctl_miso));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    cycles <= cycles + 1;
    if (cycles % DIV == DIV - 1) tick <= tick + 1;
  end
  always @(posedge mclk) begin
    if (cycles == 90000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] unused;
    txsa_host_inst.xfer(a, d, unused);
  endtask
  task automatic rd16(input logic [7:0] a);
    txsa_host_inst.xfer(a, 16'h0000, rd);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input int n);
    for (int i = 0; i < n; i++) begin
      rd16(a);
      if (rd[b] === 1'b1) break;
    end
  endtask
  task automatic watch(input int n);
    repeat (2 * DIV) @(negedge mclk);
    m1 = 1'b0;
    m2 = 1'b0;
    repeat (n * DIV) begin
      @(negedge mclk);
      m1 = m1 | (|mod_out.modulator_output_one);
      m2 = m2 | (|mod_out.modulator_output_two);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    rd16(ADDR_STATUS);
    check(rd & 16'h0803, 16'h0000);
    rd16(8'h55);
    check(rd, 16'h0000);
    rd16(ADDR_AUDIO_CTRL);
    check(rd, 16'h0000);
    wr(ADDR_PARAM, {PID_DECODER, 6'h04, 6'h04});
    wr(ADDR_PARAM, {PID_AGC, 12'h000});
    wr(ADDR_TX_OUT_MODE, {14'h0000, ROUTE_COMPOSITE});
    wr(ADDR_OUT_GAIN, 16'h0000);
    wr(ADDR_AUDIO_CTRL, 16'h0000);
    wr(ADDR_IN_GAIN, 16'h0000);
    wr(ADDR_MODE_CTRL, {14'h0000, MODE_CODE_TX});
    rd16(ADDR_STATUS);
    check(rd & 16'h0003, 16'h0002);
    watch(20);
    check({14'h0000, m1, m2}, 16'h0000);
    wr(ADDR_IN_GAIN, 16'h0008);
    watch(20);
    check({14'h0000, m1, m2}, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TX_OUT_MODE, {14'h0000, outs[i][3:2]});
      wr(ADDR_OUT_GAIN, {14'h0000, outs[i][1:0]});
      watch(20);
      check({14'h0000, m1, m2}, 16'h0003);
    end
    wr(ADDR_OUT_GAIN, 16'h0000);
    wr(ADDR_TX_OUT_MODE, {14'h0000, ROUTE_SPLIT});
    wr(ADDR_MODE_CTRL, 16'h000E);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_AUDIO_CTRL, i == 0 ? 16'h0100 : (i == 1 ? 16'h01C8 : 16'h1F00));
      watch(20);
      check({14'h0000, m1, m2}, 16'h0002);
    end
    wr(ADDR_MODE_CTRL, {14'h0000, MODE_CODE_TX});
    wr(ADDR_AUDIO_CTRL, 16'h01C9);
    watch(20);
    check({15'h0000, m2}, 16'h0000);
    wr(ADDR_MODE_CTRL, 16'h000E);
    watch(20);
    check({15'h0000, m2}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_AUDIO_CTRL, {8'h01, codes[i]});
      watch(20);
      check({15'h0000, m2}, 16'h0001);
    end
    wr(ADDR_MODE_CTRL, 16'h0000);
    watch(8);
    check({14'h0000, m1, m2}, 16'h0000);
    wr(ADDR_AUDIO_CTRL, 16'h00EE);
    wr(ADDR_MODE_CTRL, 16'h0005);
    poll(ADDR_STATUS, ST_TONE, 120);
    check(rd & 16'h0800, 16'h0800);
    rd16(ADDR_TONE_STATUS);
    check(rd & 16'h00FF, 16'h00EE);
    // Flip mid-way through a positive half so the next crossing comes half a period early
    @(posedge tick[4]);
    repeat (8 * DIV) @(negedge mclk);
    tone_flip = 1'b1;
    poll(ADDR_TONE_STATUS, TS_PHASE, 40);
    check(rd & 16'h0200, 16'h0200);
    repeat (64 * DIV) @(negedge mclk);
    rd16(ADDR_TONE_STATUS);
    rd16(ADDR_TONE_STATUS);
    check(rd & 16'h0200, 16'h0000);
    // Expandor off: receive audio follows the flipped, now negative, input
    @(posedge tick[4]);
    repeat (2 * DIV) @(negedge mclk);
    check(rx_audio, 16'hE000);
    close_out();
  end
endmodule
`default_nettype wire
